// >>> sbw_regs.svh
// Register offsets, field positions, reset values and constants of the shared bus window.
// Assumes a plain word-indexed register port; included by the top module, checker and bench.
//
// Behaviour
// - External processor makes 32-bit reads and writes on the shared bus through window registers.
// - Window is a dedicated bus master, waiting for the arbiter's grant.
// - Every transfer uses the address held in the window address register.
// - Writing the plain data register stores the word and starts a bus write.
// - Reading plain data returns held word, starts bus read, result loads data.
// - Autoincrement register shares data word; address advances by four per started access.
// - Passive data register reads and writes the word without any bus transfer.
// - Bus error sets the error flag and loads data with 0x88888888.
// - Errors only come from missing regions or illegal registers; debug aid only.
// - While busy, all three data registers read 0x88888888.
// - Reads refused as busy never advance the address.
`ifndef SBW_REGS_SVH
`define SBW_REGS_SVH

`define SBW_ADDR_CONTROL      4'h0
`define SBW_ADDR_ADDRESS      4'h1
`define SBW_ADDR_DATA         4'h2
`define SBW_ADDR_DATA_AUTOINC 4'h3
`define SBW_ADDR_DATA_PASSIVE 4'h4
`define SBW_ADDR_IRQ_STATUS   4'h5
`define SBW_ADDR_IRQ_CLEAR    4'h6
`define SBW_ADDR_IRQ_ENABLE   4'h7
`define SBW_ADDR_ID           4'h8

`define SBW_CTRL_BUSY_BIT     0
`define SBW_CTRL_ERR_BIT      1
`define SBW_IRQ_DONE_BIT      0
`define SBW_IRQ_ERR_BIT       1

`define SBW_MARKER            32'h88888888
`define SBW_ADDR_STEP         32'h00000004
`define SBW_RESET_WORD        32'h00000000
`define SBW_RESET_IRQ         2'h0
// Arbitrary value, identifies this block revision only
`define SBW_ID_VALUE          32'h5B3E0001

`endif

// >>> sbw_pkg.sv
// Types shared by the shared bus window.
// Assumes sbw_regs.svh for numeric constants.
package sbw_pkg;

  typedef enum logic [2:0] {
    SBW_IDLE  = 3'b001,
    SBW_REQ   = 3'b010,
    SBW_WAIT  = 3'b100
  } sbw_state_type;

  // Request toward the shared system bus
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] address;
    logic [31:0] wdata;
  } sbw_bus_req_type;

  // Answer from the shared system bus
  typedef struct packed {
    logic        grant;
    logic        done;
    logic        error;
    logic [31:0] rdata;
  } sbw_bus_rsp_type;

  // Register port request
  typedef struct packed {
    logic [3:0]  address;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } sbw_reg_req_type;

endpackage : sbw_pkg

// >>> sbw_window.sv
// Shared bus window: register port for an external processor and a master port
// on the shared system bus. Assumes the bus answers with done or error per transfer.
`timescale 1ns/1ps
`include "sbw_regs.svh"

module sbw_window (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Register port
  input  wire sbw_pkg::sbw_reg_req_type reg_req,
  output logic [31:0]                   reg_rdata,
  // Shared system bus master
  output sbw_pkg::sbw_bus_req_type      bus_req,
  input  wire sbw_pkg::sbw_bus_rsp_type bus_rsp,
  // Interrupt
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////////////
  sbw_pkg::sbw_state_type state;
  logic [31:0]            address;
  logic [31:0]            data;
  logic                   busy;
  logic                   err_flag;
  logic [1:0]             irq_status;
  logic [1:0]             irq_enable;
  logic                   is_data;
  logic                   is_inc;
  logic                   is_pass;
  logic                   start;
  logic                   start_write;
  logic                   finish;
  logic [1:0]             irq_event;
  logic [1:0]             irq_clear;
  logic [31:0]            next_rdata;

  assign busy    = (state != sbw_pkg::SBW_IDLE);
  assign is_data = (reg_req.address == `SBW_ADDR_DATA);
  assign is_inc  = (reg_req.address == `SBW_ADDR_DATA_AUTOINC);
  assign is_pass = (reg_req.address == `SBW_ADDR_DATA_PASSIVE);
  // Accesses while busy are refused so a transfer in flight is never overtaken
  assign start       = !busy && (is_data || is_inc) && (reg_req.read || reg_req.write);
  assign start_write = reg_req.write;
  assign finish      = (state == sbw_pkg::SBW_WAIT) && (bus_rsp.done || bus_rsp.error);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= sbw_pkg::SBW_IDLE;
    end else begin
      unique case (state)
        sbw_pkg::SBW_IDLE: begin
          if (start) begin
            state <= sbw_pkg::SBW_REQ;
          end
        end
        sbw_pkg::SBW_REQ: begin
          // Competes with other masters; holds request until granted
          if (bus_rsp.grant) begin
            state <= sbw_pkg::SBW_WAIT;
          end
        end
        sbw_pkg::SBW_WAIT: begin
          if (finish) begin
            state <= sbw_pkg::SBW_IDLE;
          end
        end
        default: begin
          state <= sbw_pkg::SBW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_req <= '0;
    end else if (start) begin
      bus_req.req     <= 1'b1;
      bus_req.write   <= start_write;
      bus_req.address <= address;
      bus_req.wdata   <= reg_req.wdata;
    end else if (state == sbw_pkg::SBW_REQ && bus_rsp.grant) begin
      bus_req.req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      address <= `SBW_RESET_WORD;
    end else if (start && is_inc) begin
      address <= address + `SBW_ADDR_STEP;
    end else if (reg_req.write && reg_req.address == `SBW_ADDR_ADDRESS && !busy) begin
      address <= reg_req.wdata;
    end
  end

  // Data word, shared by all three data registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data <= `SBW_RESET_WORD;
    end else if (finish && bus_rsp.error) begin
      data <= `SBW_MARKER;
    end else if (finish && !bus_req.write) begin
      data <= bus_rsp.rdata;
    end else if (reg_req.write && !busy && (is_data || is_inc || is_pass)) begin
      data <= reg_req.wdata;
    end
  end

  // Error flag: a write of one to its control bit clears it, a new error wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      err_flag <= 1'b0;
    end else if (finish && bus_rsp.error) begin
      err_flag <= 1'b1;
    end else if (reg_req.write && reg_req.address == `SBW_ADDR_CONTROL
                 && reg_req.wdata[`SBW_CTRL_ERR_BIT]) begin
      err_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  assign irq_event = {finish && bus_rsp.error, finish};
  assign irq_clear = (reg_req.write && reg_req.address == `SBW_ADDR_IRQ_CLEAR)
                     ? reg_req.wdata[1:0] : 2'h0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_status <= `SBW_RESET_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_enable <= `SBW_RESET_IRQ;
    end else if (reg_req.write && reg_req.address == `SBW_ADDR_IRQ_ENABLE) begin
      irq_enable <= reg_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (reg_req.address)
      `SBW_ADDR_CONTROL: begin
        next_rdata[`SBW_CTRL_BUSY_BIT] = busy;
        next_rdata[`SBW_CTRL_ERR_BIT]  = err_flag;
      end
      `SBW_ADDR_ADDRESS: begin
        next_rdata = address;
      end
      `SBW_ADDR_DATA, `SBW_ADDR_DATA_AUTOINC, `SBW_ADDR_DATA_PASSIVE: begin
        next_rdata = busy ? `SBW_MARKER : data;
      end
      `SBW_ADDR_IRQ_STATUS: begin
        next_rdata[1:0] = irq_status;
      end
      `SBW_ADDR_IRQ_ENABLE: begin
        next_rdata[1:0] = irq_enable;
      end
      `SBW_ADDR_ID: begin
        next_rdata = `SBW_ID_VALUE;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_req.read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : sbw_window

// >>> sbw_checker.sv
// Port checker for the shared bus window.
// Assumes one bus transfer at a time, ended by one done or error pulse.
`timescale 1ns/1ps
`include "sbw_regs.svh"
module sbw_checker (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     reset_n,
  // Watched ports
  input wire sbw_pkg::sbw_reg_req_type reg_req,
  input wire logic [31:0]              reg_rdata,
  input wire sbw_pkg::sbw_bus_req_type bus_req,
  input wire sbw_pkg::sbw_bus_rsp_type bus_rsp,
  input wire logic                     irq
);
  logic wait_q;
  wire  busy = bus_req.req | wait_q;
  wire  dreg = reg_req.address inside {4'h2, 4'h3};
  wire  drd  = reg_req.read && reg_req.address inside {4'h2, 4'h3, 4'h4};
  wire  pas  = (reg_req.read || reg_req.write) && reg_req.address == 4'h4;
  always_ff @(posedge clk) begin
    if (!reset_n) wait_q <= 1'b0;
    else if (bus_req.req && bus_rsp.grant) wait_q <= 1'b1;
    else if (bus_rsp.done || bus_rsp.error) wait_q <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Data access arriving while idle
  sequence s_start;
    dreg && !busy && (reg_req.read || reg_req.write);
  endsequence
  chk_rdata_idle: assert property (!reg_req.read |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_write_start: assert property (s_start ##0 reg_req.write |=> bus_req.req
    && bus_req.write && bus_req.wdata == $past(reg_req.wdata)) else $error("no bus write");
  chk_read_start: assert property (s_start ##0 reg_req.read |=> bus_req.req
    && !bus_req.write) else $error("no bus read");
  chk_req_hold: assert property (bus_req.req && !bus_rsp.grant |=> bus_req.req
    && $stable(bus_req.address)) else $error("request dropped early");
  chk_req_drop: assert property (bus_req.req && bus_rsp.grant |=> !bus_req.req)
    else $error("request kept after grant");
  chk_busy_marker: assert property (drd && busy |=> reg_rdata == `SBW_MARKER)
    else $error("no marker while busy");
  chk_passive_quiet: assert property (pas && !busy |=> !bus_req.req)
    else $error("passive access started bus");
  chk_busy_refuse: assert property (wait_q && reg_req.write && dreg |=> !bus_req.req)
    else $error("access started while busy");
  // Interrupt only rises after a transfer ends or after an enable write reaches it
  chk_irq_cause: assert property ($rose(irq) |-> $past(bus_rsp.done || bus_rsp.error)
    || $past(reg_req.write, 2)) else $error("interrupt rose without cause");
endmodule : sbw_checker

// >>> sbw_bus_model.sv
// Shared system bus partner: grants, waits a set delay, then ends with done or error.
// Assumes one request at a time; addresses with top nibble F do not exist.
`timescale 1ns/1ps
module sbw_bus_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Bus
  input  wire sbw_pkg::sbw_bus_req_type bus_req,
  output sbw_pkg::sbw_bus_rsp_type      bus_rsp,
  // Countdown length; the ending pulse comes this many plus two cycles after grant
  input  wire logic [3:0]               delay
);
  logic        act;
  logic [3:0]  cnt;
  logic [31:0] last_a;
  logic [31:0] last_d;
  wire         fire = act && !bus_rsp.grant && cnt == 4'h0;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rsp <= '0;
      act     <= 1'b0;
    end else begin
      bus_rsp.grant <= bus_req.req && !act;
      bus_rsp.done  <= fire && last_a[31:28] != 4'hF;
      bus_rsp.error <= fire && last_a[31:28] == 4'hF;
      // Stale data is scrambled so nothing reads it by luck
      bus_rsp.rdata <= fire ? last_a ^ 32'h13570000 : ~bus_rsp.rdata;
      if (bus_req.req && !act) begin
        act    <= 1'b1;
        cnt    <= delay;
        last_a <= bus_req.address;
        if (bus_req.write) last_d <= bus_req.wdata;
      end else if (fire) act <= 1'b0;
      else if (act && !bus_rsp.grant) cnt <= cnt - 4'h1;
    end
  end
endmodule : sbw_bus_model

// >>> sbw_window_test.sv
// Register-level test of the shared bus window against the bus model.
// Assumes tasks are entered right after a rising edge.
`timescale 1ns/1ps
`include "sbw_regs.svh"
module sbw_window_test;
  logic                      clk;
  logic                      reset_n;
  logic                      irq;
  logic [31:0]               reg_rdata;
  logic [31:0]               v;
  logic [3:0]                dly;
  sbw_pkg::sbw_reg_req_type  rq;
  sbw_pkg::sbw_bus_req_type  breq;
  sbw_pkg::sbw_bus_rsp_type  brsp;
  int                        mismatches;
  int                        checked;
  int                        cyc;
  sbw_window dut (.clk(clk), .reset_n(reset_n), .reg_req(rq), .reg_rdata(reg_rdata),
    .bus_req(breq), .bus_rsp(brsp), .irq(irq));
  sbw_bus_model m (.clk(clk), .reset_n(reset_n), .bus_req(breq), .bus_rsp(brsp), .delay(dly));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic acc(input logic [3:0] a, input logic [31:0] d, input logic w,
                     output logic [31:0] r);
    rq <= '{address: a, wdata: d, write: w, read: !w};
    @(posedge clk);
    rq <= '0;
    // Read data stand one cycle only; look mid-cycle, hand back on a rising edge
    @(negedge clk);
    r = reg_rdata;
    @(posedge clk);
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(a, d, 1'b1, r);
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    acc(a, 32'h0, 1'b0, r);
    chk(r, e);
  endtask : rc
  // Bounded poll of the busy bit
  task automatic idle;
    logic [31:0] r;
    r = 32'h1;
    for (int n = 0; n < 50 && r[0] !== 1'b0; n++) acc(4'h0, 32'h0, 1'b0, r);
    chk(r[0], 32'h0);
  endtask : idle
  function automatic logic [31:0] f(input logic [31:0] a);
    return a ^ 32'h13570000;
  endfunction : f
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {mismatches, checked, cyc} = '0;
    reset_n = 1'b0;
    rq = '0;
    dly = 4'h3;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rc(4'h8, `SBW_ID_VALUE);
    rc(4'h0, 32'h0);
    rc(4'h9, 32'h0);
    $display("test reset done");
    wr(4'h1, 32'h100);
    for (int i = 0; i < 4; i++) wr(4'h2, 32'hA0 + i);
    idle();
    chk(m.last_a, 32'h100);
    chk(m.last_d, 32'hA0);
    wr(4'h1, 32'h200);
    rc(4'h2, 32'hA0);
    rc(4'h4, `SBW_MARKER);
    idle();
    rc(4'h4, f(32'h200));
    $display("test plain done");
    wr(4'h7, 32'h3);
    rc(4'h5, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(4'h6, 32'h3);
    rc(4'h5, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(4'h1, 32'h300);
    rc(4'h3, f(32'h200));
    rc(4'h3, `SBW_MARKER);
    idle();
    rc(4'h1, 32'h304);
    rc(4'h4, f(32'h300));
    wr(4'h3, 32'h55);
    idle();
    chk(m.last_a, 32'h304);
    rc(4'h1, 32'h308);
    wr(4'h4, 32'h77);
    rc(4'h4, 32'h77);
    chk(m.last_a, 32'h304);
    $display("test autoinc done");
    wr(4'h1, 32'hF0000000);
    rc(4'h2, 32'h77);
    idle();
    rc(4'h0, 32'h2);
    rc(4'h4, `SBW_MARKER);
    acc(4'h5, 32'h0, 1'b0, v);
    chk(v & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(4'h1, 32'h400);
    wr(4'h2, 32'h99);
    idle();
    rc(4'h0, 32'h2);
    wr(4'h0, 32'h2);
    rc(4'h0, 32'h0);
    $display("test error done");
    give_verdict();
  end
endmodule : sbw_window_test
bind sbw_window sbw_checker chk_i (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_rsp(bus_rsp), .irq(irq));
